/* File: sim/interrupt_vector_flag_map_test.sv */
`timescale 1ns/1ps
module interrupt_vector_flag_map_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [13:0] adr_i = 14'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic        fire  = 1'b0;
    logic [4:0]  src   = 5'h0;
    logic [22:0] ev;
    logic [15:0] q;
    logic [15:0] m;
    logic [13:0] fb;
    wire  [31:0] dat_o;
    wire         ack_o;
    wire         irq_req_o;
    wire  [7:0]  irq_vector_o;
    wire  [7:0]  irq_number_o;
    wire  [23:0] irq_table_addr_o;
    wire  [2:0]  irq_priority_o;
    wire         irq_other_o;
    integer      failures = 0;
    integer      compares = 0;
    // Row: vector, flag register number, flag bit; order matches the source model's index.
    logic [15:0] rows [0:22] = '{16'h8078, 16'h8179, 16'h827a, 16'h837b, 16'h847c, 16'h857d, 16'hb7af, 16'hb8b0,
        16'hb9b1, 16'hbab2, 16'hbbb3, 16'hbcb4, 16'h867e, 16'h877f, 16'hb1a9, 16'hb2aa, 16'hb3ab, 16'hb4ac,
        16'hb5ad, 16'hb6ae, 16'hc5bd, 16'hc6be, 16'hc7bf};
    initial forever #10 clk_i = ~clk_i;
    ivfm_src_model ivfm_src_model_i (.clk_i, .fire_i(fire), .src_i(src), .ev_o(ev));
    ivfm_top ivfm_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .lower_event_i(112'h0), .comparator_event_i(4'h0), .oversample_filter_event_i(ev[3:0]),
        .logic_cell_rising_i(ev[7:4]), .logic_cell_falling_i(ev[11:8]), .serial_port_error_i(ev[13:12]),
        .pwm_event_i(ev[19:14]), .uart_event_i(ev[22:20]), .irq_req_o, .irq_vector_o, .irq_number_o,
        .irq_table_addr_o, .irq_priority_o, .irq_other_o);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task automatic bus(input logic w, input logic [13:0] a, input logic [15:0] d);
        integer n;
    begin
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= {16'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        if (n == 50)
            chk(1'b0, 1'b1);
        q = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    end
    endtask
    task automatic pulse(input logic [4:0] k);
        fire <= 1'b1;
        src  <= k;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic complete_run;
    begin
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    initial
    begin
        do_reset;
        for (int i = 0; i < 23; i++)
        begin
            fb = 14'h2000 + {7'h0, rows[i][7:4], 3'h0};
            m = 16'h1 << rows[i][3:0];
            bus(1'b1, fb + 14'h0080, m);
            pulse(i[4:0]);
            chk(irq_req_o, 1'b1);
            chk(irq_vector_o, rows[i][15:8]);
            chk(irq_number_o, rows[i][15:8] - 8'h08);
            chk(irq_table_addr_o, {15'h0, rows[i][15:8], 1'b0} + 24'h4);
            bus(1'b0, fb, 16'h0);
            chk(q, m);
            bus(1'b1, fb, 16'h0);
            bus(1'b1, fb + 14'h0080, 16'h0);
            repeat (2) @(posedge clk_i);
            chk(irq_req_o, 1'b0);
        end
        $display("test vectors done");
        bus(1'b1, 14'h2038, 16'hffff); bus(1'b0, 14'h2038, 16'h0); chk(q, 16'hfff0);
        bus(1'b1, 14'h2050, 16'hffff); bus(1'b0, 14'h2050, 16'h0); chk(q, 16'hfe00);
        bus(1'b1, 14'h2058, 16'hffff); bus(1'b0, 14'h2058, 16'h0); chk(q, 16'he01f);
        bus(1'b1, 14'h3ffc, 16'hffff); bus(1'b0, 14'h3ffc, 16'h0); chk(q, 16'h0);
        bus(1'b1, 14'h2038, 16'h0); bus(1'b1, 14'h2050, 16'h0); bus(1'b1, 14'h2058, 16'h0);
        $display("test layout done");
        bus(1'b1, 14'h21f0, 16'hffff); bus(1'b0, 14'h21f0, 16'h0); chk(q, 16'h7777);
        bus(1'b1, 14'h21f0, 16'h5000);
        bus(1'b1, 14'h20b8, 16'h0900);
        pulse(5'd0);
        pulse(5'd3);
        chk(irq_vector_o, 8'd131);
        chk(irq_priority_o, 3'd5);
        bus(1'b1, 14'h21f0, 16'h0003);
        repeat (2) @(posedge clk_i);
        chk(irq_vector_o, 8'd128);
        chk(irq_priority_o, 3'd3);
        pulse(5'd1);
        chk(irq_vector_o, 8'd128);
        bus(1'b0, 14'h2038, 16'h0); chk(q, 16'h0b00);
        bus(1'b0, 14'h2300, 16'h0);
        chk(dat_o, 32'h8300_8078);
        chk(irq_other_o, 1'b0);
        bus(1'b1, 14'h2038, 16'h0010);
        bus(1'b1, 14'h20b8, 16'h0010);
        repeat (2) @(posedge clk_i);
        chk(irq_other_o, 1'b1);
        chk(irq_req_o, 1'b0);
        $display("test priority done");
        do_reset;
        chk(irq_req_o, 1'b0);
        chk(irq_other_o, 1'b0);
        bus(1'b0, 14'h2038, 16'h0); chk(q, 16'h0);
        bus(1'b0, 14'h20b8, 16'h0); chk(q, 16'h0);
        $display("test reset done");
        complete_run;
    end
    // The tests need about five hundred cycles; twenty times that means a hang.
    initial
    begin
        #200000;
        failures = failures + 1;
        complete_run;
    end
endmodule // interrupt_vector_flag_map_test

/* File: sim/ivfm_props.sv */
`timescale 1ns/1ps
module ivfm_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic        ack_o,
    input wire logic        irq_req_o,
    input wire logic [7:0]  irq_vector_o,
    input wire logic [7:0]  irq_number_o,
    input wire logic [23:0] irq_table_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_pulse;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_after_take: assert property (s_take |=> s_pulse)
        else $error("request not answered by a single ack");
    a_ack_when_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_irq_number: assert property (irq_req_o |-> irq_number_o == irq_vector_o - 8'h08)
        else $error("irq number not vector minus eight");
    a_table_step: assert property (irq_req_o |-> irq_table_addr_o == {15'h0, irq_vector_o, 1'b0} + 24'h4)
        else $error("table address off");
    a_vector_band: assert property (irq_req_o |-> irq_vector_o inside {[128:135], [177:188], [197:199]})
        else $error("request on reserved vector");
    a_idle_vector: assert property (!irq_req_o |-> irq_vector_o == 8'h00)
        else $error("vector shown without request");
    a_clear_by_write: assert property ($fell(irq_req_o) |-> $past(ack_o && we_i, 2) || $past(ack_o && we_i))
        else $error("request dropped without software write");
    a_req_holds: assert property (irq_req_o && !(ack_o && we_i) && !$past(ack_o && we_i) |=> irq_req_o)
        else $error("request dropped on its own");
endmodule // ivfm_props

bind ivfm_top ivfm_props ivfm_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .irq_req_o, .irq_vector_o,
    .irq_number_o, .irq_table_addr_o);

/* File: sim/ivfm_src_model.sv */
`timescale 1ns/1ps
module ivfm_src_model (
    input  wire logic        clk_i,
    input  wire logic        fire_i,
    input  wire logic [4:0]  src_i,
    output logic      [22:0] ev_o
);
    // One occurrence gives a single-cycle pulse, so a held flag proves the block latched it.
    always @(posedge clk_i)
    begin
        ev_o <= fire_i ? (23'h1 << src_i) : 23'h0;
    end
endmodule // ivfm_src_model

/* File: src/ivfm_defs.vh */
`ifndef IVFM_DEFS_VH
`define IVFM_DEFS_VH

// Register indices; the Wishbone byte address is four times the index.
`define IVFM_FLAG0_IDX  12'h800
`define IVFM_FLAG1_IDX  12'h802
`define IVFM_FLAG2_IDX  12'h804
`define IVFM_FLAG3_IDX  12'h806
`define IVFM_FLAG4_IDX  12'h808
`define IVFM_FLAG5_IDX  12'h80a
`define IVFM_FLAG6_IDX  12'h80c
`define IVFM_FLAG7_IDX  12'h80e
`define IVFM_FLAG10_IDX 12'h814
`define IVFM_FLAG11_IDX 12'h816
`define IVFM_EN_DELTA   12'h020
`define IVFM_PRI30_IDX  12'h87c
`define IVFM_PRI31_IDX  12'h87e
`define IVFM_PRI42_IDX  12'h894
`define IVFM_PRI43_IDX  12'h896
`define IVFM_PRI44_IDX  12'h898
`define IVFM_PRI45_IDX  12'h89a
`define IVFM_PRI47_IDX  12'h89e
`define IVFM_STAT_IDX   12'h8c0

// Implemented flag positions per flag register.
`define IVFM_MASK0  16'hffdf
`define IVFM_MASK1  16'h7dbf
`define IVFM_MASK2  16'h2318
`define IVFM_MASK3  16'ha70f
`define IVFM_MASK4  16'h2879
`define IVFM_MASK5  16'hfcfe
`define IVFM_MASK6  16'h1fff
`define IVFM_MASK7  16'hfff0
`define IVFM_MASK10 16'hfe00
`define IVFM_MASK11 16'he01f
`define IVFM_PRI_MASK 16'h7777

// Reset values.
`define IVFM_FLAG_RST 16'h0000
`define IVFM_EN_RST   16'h0000
`define IVFM_PRI_RST  16'h0000

// Flag bit positions of the vectored sources.
`define IVFM_FLT_LSB  8
`define IVFM_CLCR_LSB 12
`define IVFM_SPI_LSB  14
`define IVFM_PWM_LSB  9
`define IVFM_UART_LSB 13

// Vector numbering.
`define IVFM_VEC_BASE   8'h80
`define IVFM_VEC_SPAN   72
`define IVFM_IRQ_OFFSET 8'h08
`define IVFM_VT_BASE    24'h000004

`endif

/* File: src/ivfm_reg16.v */
`timescale 1ns/1ps
module ivfm_reg16 #(
    parameter [15:0] IMPL = 16'hffff,
    parameter [15:0] RST  = 16'h0000
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wr_i,
    input  wire [15:0] wmask_i,
    input  wire [15:0] wdata_i,
    input  wire [15:0] set_i,
    output wire [15:0] q_o
);
    reg  [15:0] q_r;
    wire [15:0] q_nxt;

    // Set wins over a clear that lands in the same cycle.
    assign q_nxt = ((wr_i ? ((q_r & ~wmask_i) | (wdata_i & wmask_i)) : q_r) | set_i) & IMPL;
    assign q_o   = q_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
            q_r <= RST & IMPL;
        else
            q_r <= q_nxt;
    end
endmodule // ivfm_reg16

/* File: src/ivfm_top.v */
`timescale 1ns/1ps
`include "ivfm_defs.vh"
module ivfm_top (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         cyc_i,
    input  wire         stb_i,
    input  wire         we_i,
    input  wire [13:0]  adr_i,
    input  wire [3:0]   sel_i,
    input  wire [31:0]  dat_i,
    output wire [31:0]  dat_o,
    output wire         ack_o,
    input  wire [111:0] lower_event_i,
    input  wire [3:0]   comparator_event_i,
    input  wire [3:0]   oversample_filter_event_i,
    input  wire [3:0]   logic_cell_rising_i,
    input  wire [3:0]   logic_cell_falling_i,
    input  wire [1:0]   serial_port_error_i,
    input  wire [5:0]   pwm_event_i,
    input  wire [2:0]   uart_event_i,
    output wire         irq_req_o,
    output wire [7:0]   irq_vector_o,
    output wire [7:0]   irq_number_o,
    output wire [23:0]  irq_table_addr_o,
    output wire [2:0]   irq_priority_o,
    output wire         irq_other_o
);
    localparam NFLAG = 10;
    localparam NPRI  = 7;
    localparam NSRC  = `IVFM_VEC_SPAN;

    localparam [NFLAG*12-1:0] FLAG_IDX = {
        `IVFM_FLAG11_IDX, `IVFM_FLAG10_IDX, `IVFM_FLAG7_IDX, `IVFM_FLAG6_IDX,
        `IVFM_FLAG5_IDX, `IVFM_FLAG4_IDX, `IVFM_FLAG3_IDX, `IVFM_FLAG2_IDX,
        `IVFM_FLAG1_IDX, `IVFM_FLAG0_IDX};
    localparam [NFLAG*16-1:0] FLAG_MASK = {
        `IVFM_MASK11, `IVFM_MASK10, `IVFM_MASK7, `IVFM_MASK6,
        `IVFM_MASK5, `IVFM_MASK4, `IVFM_MASK3, `IVFM_MASK2,
        `IVFM_MASK1, `IVFM_MASK0};
    localparam [NPRI*12-1:0] PRI_IDX = {
        `IVFM_PRI47_IDX, `IVFM_PRI45_IDX, `IVFM_PRI44_IDX, `IVFM_PRI43_IDX,
        `IVFM_PRI42_IDX, `IVFM_PRI31_IDX, `IVFM_PRI30_IDX};

    reg          ack_r;
    wire         ack_nxt;
    reg  [31:0]  dat_r;
    reg  [31:0]  dat_nxt;
    reg          irq_req_r;
    reg  [7:0]   irq_vector_r;
    reg  [7:0]   irq_number_r;
    reg  [23:0]  irq_table_addr_r;
    reg  [2:0]   irq_priority_r;
    reg          irq_other_r;

    wire [11:0]  idx;
    wire         wr_go;
    wire [15:0]  wmask;
    wire [NFLAG*16-1:0] flag_set;
    wire [NFLAG*16-1:0] flag_q;
    wire [NFLAG*16-1:0] en_q;
    wire [NPRI*16-1:0]  pri_q;
    wire [NSRC-1:0]     pend;
    wire [NSRC*3-1:0]   pri_w;

    reg          found;
    reg  [2:0]   best_pri;
    reg  [6:0]   best_idx;
    reg          hit;
    reg  [7:0]   best_vec;
    integer      i;

    assign idx   = adr_i[13:2];
    assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

    // A write lands on the edge where the master samples ack, so it happens once.
    assign wr_go   = cyc_i & stb_i & we_i & ack_r;
    assign ack_nxt = cyc_i & stb_i & ~ack_r;

    // Source events into the flag registers.
    assign flag_set[7*16-1:0] = lower_event_i;
    assign flag_set[7*16+:16] = {serial_port_error_i[1],
                                 serial_port_error_i[0],
                                 logic_cell_rising_i[1:0],
                                 oversample_filter_event_i,
                                 comparator_event_i,
                                 4'h0};
    assign flag_set[8*16+:16] = {logic_cell_rising_i[2], pwm_event_i, 9'h000};
    assign flag_set[9*16+:16] = {uart_event_i, 8'h00,
                                 logic_cell_falling_i,
                                 logic_cell_rising_i[3]};

    genvar g;
    generate
        for (g = 0; g < NFLAG; g = g + 1)
        begin : g_flag
            ivfm_reg16 #(
                .IMPL (FLAG_MASK[g*16+:16]),
                .RST  (`IVFM_FLAG_RST)
            ) u_flag (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .wr_i    (wr_go && (idx == FLAG_IDX[g*12+:12])),
                .wmask_i (wmask),
                .wdata_i (dat_i[15:0]),
                .set_i   (flag_set[g*16+:16]),
                .q_o     (flag_q[g*16+:16])
            );
            ivfm_reg16 #(
                .IMPL (FLAG_MASK[g*16+:16]),
                .RST  (`IVFM_EN_RST)
            ) u_en (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .wr_i    (wr_go && (idx == FLAG_IDX[g*12+:12] + `IVFM_EN_DELTA)),
                .wmask_i (wmask),
                .wdata_i (dat_i[15:0]),
                .set_i   (16'h0000),
                .q_o     (en_q[g*16+:16])
            );
        end
        for (g = 0; g < NPRI; g = g + 1)
        begin : g_pri
            ivfm_reg16 #(
                .IMPL (`IVFM_PRI_MASK),
                .RST  (`IVFM_PRI_RST)
            ) u_pri (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .wr_i    (wr_go && (idx == PRI_IDX[g*12+:12])),
                .wmask_i (wmask),
                .wdata_i (dat_i[15:0]),
                .set_i   (16'h0000),
                .q_o     (pri_q[g*16+:16])
            );
        end
    endgenerate

    // Pending sources indexed by vector minus 128; reserved vectors never pend.
    assign pend[3:0]   = flag_q[7*16+8+:4] & en_q[7*16+8+:4];
    assign pend[7:4]   = flag_q[7*16+12+:4] & en_q[7*16+12+:4];
    assign pend[48:8]  = 41'h0;
    assign pend[55:49] = flag_q[8*16+9+:7] & en_q[8*16+9+:7];
    assign pend[60:56] = flag_q[9*16+:5] & en_q[9*16+:5];
    assign pend[68:61] = 8'h00;
    assign pend[71:69] = flag_q[9*16+13+:3] & en_q[9*16+13+:3];

    // Priority fields per source, three bits each.
    assign pri_w[3*4-1:0] = {pri_q[0*16+12+:3], pri_q[0*16+8+:3],
                             pri_q[0*16+4+:3], pri_q[0*16+:3]};
    assign pri_w[3*8-1:3*4] = {pri_q[1*16+12+:3], pri_q[1*16+8+:3],
                               pri_q[1*16+4+:3], pri_q[1*16+:3]};
    assign pri_w[3*49-1:3*8] = 123'h0;
    assign pri_w[3*52-1:3*49] = {pri_q[2*16+12+:3], pri_q[2*16+8+:3],
                                 pri_q[2*16+4+:3]};
    assign pri_w[3*56-1:3*52] = {pri_q[3*16+12+:3], pri_q[3*16+8+:3],
                                 pri_q[3*16+4+:3], pri_q[3*16+:3]};
    assign pri_w[3*60-1:3*56] = {pri_q[4*16+12+:3], pri_q[4*16+8+:3],
                                 pri_q[4*16+4+:3], pri_q[4*16+:3]};
    assign pri_w[3*61-1:3*60] = pri_q[5*16+:3];
    assign pri_w[3*69-1:3*61] = 24'h0;
    assign pri_w[3*72-1:3*69] = {pri_q[6*16+12+:3], pri_q[6*16+8+:3],
                                 pri_q[6*16+4+:3]};

    // Highest priority wins; among equals the lower vector wins.
    // A full scan each cycle costs a long compare chain but adds no latency.
    always @*
    begin
        found    = 1'b0;
        best_pri = 3'h0;
        best_idx = 7'h00;
        for (i = 0; i < NSRC; i = i + 1)
        begin
            if (pend[i] && (!found || (pri_w[i*3+:3] > best_pri)))
            begin
                found    = 1'b1;
                best_pri = pri_w[i*3+:3];
                best_idx = i[6:0];
            end
        end
        best_vec = `IVFM_VEC_BASE | {1'b0, best_idx};
    end

    // Register read mux; unmapped words read as zero.
    always @*
    begin
        dat_nxt = 32'h0000_0000;
        hit     = 1'b0;
        for (i = 0; i < NFLAG; i = i + 1)
        begin
            if (idx == FLAG_IDX[i*12+:12])
            begin
                dat_nxt = {16'h0000, flag_q[i*16+:16]};
                hit     = 1'b1;
            end
            if (idx == FLAG_IDX[i*12+:12] + `IVFM_EN_DELTA)
            begin
                dat_nxt = {16'h0000, en_q[i*16+:16]};
                hit     = 1'b1;
            end
        end
        for (i = 0; i < NPRI; i = i + 1)
        begin
            if (idx == PRI_IDX[i*12+:12])
            begin
                dat_nxt = {16'h0000, pri_q[i*16+:16]};
                hit     = 1'b1;
            end
        end
        if (!hit && (idx == `IVFM_STAT_IDX))
            dat_nxt = {irq_req_r, 4'h0, irq_priority_r, 8'h00, irq_vector_r, irq_number_r};
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r            <= 1'b0;
            dat_r            <= 32'h0000_0000;
            irq_req_r        <= 1'b0;
            irq_vector_r     <= 8'h00;
            irq_number_r     <= 8'h00;
            irq_table_addr_r <= 24'h000000;
            irq_priority_r   <= 3'h0;
            irq_other_r      <= 1'b0;
        end
        else
        begin
            ack_r <= ack_nxt;
            if (ack_nxt)
                dat_r <= dat_nxt;
            irq_req_r        <= found;
            irq_vector_r     <= found ? best_vec : 8'h00;
            irq_number_r     <= found ? (best_vec - `IVFM_IRQ_OFFSET) : 8'h00;
            irq_table_addr_r <= found ? (`IVFM_VT_BASE + {15'h0000, best_vec, 1'b0}) : 24'h000000;
            irq_priority_r   <= found ? best_pri : 3'h0;
            irq_other_r      <= |((flag_q[7*16-1:0] & en_q[7*16-1:0])) |
                                |(flag_q[7*16+4+:4] & en_q[7*16+4+:4]);
        end
    end

    assign ack_o            = ack_r;
    assign dat_o            = dat_r;
    assign irq_req_o        = irq_req_r;
    assign irq_vector_o     = irq_vector_r;
    assign irq_number_o     = irq_number_r;
    assign irq_table_addr_o = irq_table_addr_r;
    assign irq_priority_o   = irq_priority_r;
    assign irq_other_o      = irq_other_r;
endmodule // ivfm_top
